// File: asrwt_ctrl.sv
// Purpose: host controller driving an asynchronous 1M x 16 SRAM
// Assumes: one request at a time; pins driven from flops
// Notes:   output enable stays high during writes, so the bus never fights
module asrwt_ctrl
	import asrwt_pkg::*;
#(
	parameter int GRADE = asrwt_pkg::DEF_GRADE
) (
	// clock and reset
	input  logic                        clk_in,
	input  logic                        rst_n_in,
	// user request
	input  logic                        req_valid_in,
	output logic                        req_ready_out,
	input  logic                        req_write_in,
	input  logic [asrwt_pkg::ADDR_W-1:0] req_addr_in,
	input  logic [asrwt_pkg::DATA_W-1:0] req_wdata_in,
	input  logic [1:0]                  req_byte_en_in,
	// user response
	output logic                        rsp_valid_out,
	output logic [asrwt_pkg::DATA_W-1:0] rsp_rdata_out,
	// memory pins
	output logic [asrwt_pkg::ADDR_W-1:0] mem_addr_out,
	output logic                        first_chip_select_n_out,
	output logic                        second_chip_select_high_out,
	output logic                        output_enable_n_out,
	output logic                        write_enable_n_out,
	output logic                        upper_byte_n_out,
	output logic                        lower_byte_n_out,
	input  logic [asrwt_pkg::DATA_W-1:0] mem_data_in,
	output logic [asrwt_pkg::DATA_W-1:0] mem_data_out,
	output logic                        mem_data_oe_out
);
	import asrwt_pkg::*;

	// ------------------------------------------------------------------
	// phase lengths in cycles
	// ------------------------------------------------------------------
	localparam int WE_LOW_CYC = asrwt_max(
		asrwt_max(asrwt_cyc(T_PWE1_X10[GRADE]), asrwt_cyc(T_SCS_X10[GRADE])),
		asrwt_max(asrwt_max(asrwt_cyc(T_AW_X10[GRADE]),
		asrwt_cyc(T_PWB_X10[GRADE])), asrwt_cyc(T_SD_X10[GRADE])));
	localparam int WR_CYC     = asrwt_max(asrwt_cyc(T_WC_X10[GRADE]),
		WE_LOW_CYC + 1);
	localparam int WR_END_CYC = WR_CYC - WE_LOW_CYC;
	// two extra cycles let the sampled bus pass the synchroniser
	localparam int RD_CYC     = asrwt_max(asrwt_cyc(T_AA_X10[GRADE]),
		asrwt_cyc(T_RC_X10[GRADE])) + SYNC_STAGES;
	localparam int TURN_CYC   = asrwt_cyc(T_HZOE_X10[GRADE]);
	localparam int TW         = 4;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	asrwt_regs_type    r_q;
	asrwt_regs_type    r_d;
	logic              tmr_load;
	logic [TW-1:0]     tmr_value;
	logic              tmr_done;
	logic [DATA_W-1:0] data_sync;
	logic              req_take;

	asrwt_timer #(
		.WIDTH (TW)
	) u_timer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.load_in  (tmr_load),
		.value_in (tmr_value),
		.done_out (tmr_done)
	);

	asrwt_sync2 #(
		.WIDTH (DATA_W)
	) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in (mem_data_in),
		.sync_out (data_sync)
	);

	assign req_take = req_valid_in && (r_q.st == ST_IDLE);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		r_d           = r_q;
		r_d.rsp_valid = 1'b0;
		tmr_load      = 1'b0;
		tmr_value     = '0;
		case (r_q.st)
			ST_IDLE: begin
				if (req_valid_in) begin
					r_d.addr  = req_addr_in;
					r_d.wdata = req_wdata_in;
					r_d.be_n  = ~req_byte_en_in;
					r_d.cs_n  = 1'b0;
					tmr_load  = 1'b1;
					if (req_write_in) begin
						// all controls and data go active together
						r_d.we_n  = 1'b0;
						r_d.oe_n  = 1'b1;
						r_d.dq_oe = 1'b1;
						r_d.st    = ST_WR_LOW;
						tmr_value = TW'(WE_LOW_CYC);
					end else begin
						r_d.oe_n  = 1'b0;
						r_d.st    = ST_RD_WAIT;
						tmr_value = TW'(RD_CYC);
					end
				end
			end
			ST_WR_LOW: begin
				if (tmr_done) begin
					// write enable alone ends the write; data held this cycle
					r_d.we_n  = 1'b1;
					r_d.st    = ST_WR_END;
					tmr_load  = 1'b1;
					tmr_value = TW'(WR_END_CYC);
				end
			end
			ST_WR_END: begin
				if (tmr_done) begin
					r_d.cs_n  = 1'b1;
					r_d.be_n  = 2'h3;
					r_d.dq_oe = 1'b0;
					r_d.st    = ST_IDLE;
				end
			end
			ST_RD_WAIT: begin
				if (tmr_done) begin
					r_d.rdata[7:0]  = r_q.be_n[0] ? 8'h00 : data_sync[7:0];
					r_d.rdata[15:8] = r_q.be_n[1] ? 8'h00 : data_sync[15:8];
					r_d.rsp_valid   = 1'b1;
					r_d.cs_n        = 1'b1;
					r_d.oe_n        = 1'b1;
					r_d.be_n        = 2'h3;
					r_d.st          = ST_TURN;
					tmr_load        = 1'b1;
					// memory may still drive the bus for its release time
					tmr_value       = TW'(TURN_CYC);
				end
			end
			ST_TURN: begin
				if (tmr_done) begin
					r_d.st = ST_IDLE;
				end
			end
			default: begin
				r_d = REGS_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r_q <= REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign req_ready_out               = (r_q.st == ST_IDLE);
	assign rsp_valid_out               = r_q.rsp_valid;
	assign rsp_rdata_out               = r_q.rdata;
	assign mem_addr_out                = r_q.addr;
	assign first_chip_select_n_out     = r_q.cs_n;
	assign second_chip_select_high_out = ~r_q.cs_n;
	assign output_enable_n_out         = r_q.oe_n;
	assign write_enable_n_out          = r_q.we_n;
	assign upper_byte_n_out            = r_q.be_n[1];
	assign lower_byte_n_out            = r_q.be_n[0];
	assign mem_data_out                = r_q.wdata;
	assign mem_data_oe_out             = r_q.dq_oe;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	logic [7:0] we_low_cnt_q;
	logic [7:0] rd_gap_cnt_q;
	logic [7:0] wr_len_cnt_q;
	logic       rd_start;
	logic       wr_start;

	assign rd_start = req_take && !req_write_in;
	assign wr_start = req_take && req_write_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			we_low_cnt_q <= 8'h00;
			rd_gap_cnt_q <= 8'hFF;
			wr_len_cnt_q <= 8'h00;
		end else begin
			we_low_cnt_q <= r_q.we_n ? 8'h00 : we_low_cnt_q + 8'h01;
			if (rd_start) begin
				rd_gap_cnt_q <= 8'h00;
			end else if (rd_gap_cnt_q != 8'hFF) begin
				rd_gap_cnt_q <= rd_gap_cnt_q + 8'h01;
			end
			wr_len_cnt_q <= wr_start ? 8'h01 :
				((r_q.st == ST_WR_LOW || r_q.st == ST_WR_END) ?
				wr_len_cnt_q + 8'h01 : 8'h00);
		end
	end

	sequence s_write_end;
		$rose(r_q.we_n);
	endsequence

	sequence s_read_start;
		rd_start;
	endsequence

	a_write_overlap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!r_q.we_n |-> !r_q.cs_n && (r_q.be_n != 2'h3))
		else $error("write enable low without select or byte enable");

	a_write_oe_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!r_q.we_n |-> r_q.oe_n)
		else $error("output enable low during write");

	a_bus_no_fight: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		r_q.dq_oe |-> r_q.oe_n && $past(r_q.oe_n))
		else $error("host drives bus while memory may drive");

	a_we_pulse_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_write_end |-> we_low_cnt_q >= 8'(WE_LOW_CYC))
		else $error("write enable pulse too short");

	a_data_at_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_write_end |-> r_q.dq_oe && $stable(r_q.wdata)
			&& $past(r_q.dq_oe))
		else $error("write data not held across write end");

	a_ctrl_at_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_write_end |-> !r_q.cs_n && $stable(r_q.be_n)
			&& $stable(r_q.addr) && !$past(r_q.cs_n))
		else $error("select, byte or address moved before write end");

	a_addr_steady: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!r_q.cs_n && $past(!r_q.cs_n)) |-> $stable(r_q.addr))
		else $error("address changed inside a cycle");

	a_read_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_read_start |-> rd_gap_cnt_q >= 8'(RD_CYC))
		else $error("read cycles too close");

	a_read_answer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_read_start |-> ##1 (!r_q.oe_n && !r_q.cs_n)
			##[1:15] r_q.rsp_valid)
		else $error("read answer missing");

	a_write_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(r_q.st == ST_WR_END && r_d.st == ST_IDLE)
			|-> wr_len_cnt_q >= 8'(WR_CYC))
		else $error("write cycle too short");

	a_turn_gap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(r_q.oe_n) |-> !r_q.dq_oe ##1 !r_q.dq_oe)
		else $error("drive started during bus release");

	// ------------------------------------------------------------------
	// pin discipline checks
	// ------------------------------------------------------------------
	sequence s_write_begin;
		$fell(r_q.we_n);
	endsequence

	a_write_start: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		s_write_begin |-> !r_q.cs_n && (r_q.be_n != 2'h3) && r_q.dq_oe)
		else $error("write began before all controls were active");

	a_bytes_steady: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(!r_q.we_n && $past(!r_q.we_n)) |-> $stable(r_q.be_n))
		else $error("byte enable moved while write enable low");

	a_data_steady: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(r_q.dq_oe && $past(r_q.dq_oe)) |-> $stable(r_q.wdata))
		else $error("write data moved while driven");

	a_read_only: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!r_q.oe_n |-> r_q.we_n && !r_q.cs_n && !r_q.dq_oe)
		else $error("output enable low outside a clean read");

	a_rsp_single: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		r_q.rsp_valid |=> !r_q.rsp_valid)
		else $error("read answer longer than one cycle");

	// lanes are already released when the answer stands
	a_lane_zero: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		(r_q.rsp_valid && $past(r_q.be_n[0])) |-> (r_q.rdata[7:0] == 8'h00))
		else $error("disabled low lane not read as zero");

endmodule : asrwt_ctrl

// File: asrwt_pkg.sv
// Purpose: constants and types for the asynchronous SRAM host controller
// Assumes: 50 MHz clk_in; every pin time in tenths of ns, per speed grade
// Notes:   grade index 0 = 8 ns part, 1 = 10 ns part, 2 = 20 ns part
//
// Functional notes
// - Array write happens only while select, a byte enable and write enable are low.
// - All write controls active before write starts; any one going inactive ends it.
// - Data setup and hold are measured from the edge that ends the write.
// - Consecutive read cycles spaced by at least the read cycle time.
// - Each write cycle lasts at least the write cycle time.
// - Select held low at least its minimum before the write-ending edge.
// - Write address stable at least its minimum before write end.
// - Each active byte enable held low its minimum before write end.
// - Address may change right at write end; zero setup before write start.
// - Write enable low pulse meets its minimum, longer when output enable low.
// - Write data presented setup time before write end; zero hold after.
// - With output enable low, write cycle covers release delay plus data setup.
// - Host never drives data while memory may still drive from a read.
// - Host keeps output enable high for the whole of every write.
package asrwt_pkg;

	// ------------------------------------------------------------------
	// widths and clock
	// ------------------------------------------------------------------
	localparam int ADDR_W         = 20;
	localparam int DATA_W         = 16;
	localparam int CLK_PERIOD_X10 = 200;
	localparam int SYNC_STAGES    = 2;
	localparam int DEF_GRADE      = 2;

	// ------------------------------------------------------------------
	// pin times, tenths of ns, index = grade
	// ------------------------------------------------------------------
	localparam int T_RC_X10[3]    = '{80, 100, 200};
	localparam int T_AA_X10[3]    = '{80, 100, 200};
	localparam int T_HZOE_X10[3]  = '{40, 50, 80};
	localparam int T_WC_X10[3]    = '{80, 100, 200};
	localparam int T_SCS_X10[3]   = '{65, 80, 120};
	localparam int T_AW_X10[3]    = '{65, 80, 120};
	localparam int T_PWB_X10[3]   = '{65, 80, 120};
	localparam int T_PWE1_X10[3]  = '{65, 80, 120};
	localparam int T_SD_X10[3]    = '{50, 60, 90};

	// least time to whole cycles, rounded up, never below one
	function automatic int asrwt_cyc(input int t_x10);
		int c;
		c = (t_x10 + CLK_PERIOD_X10 - 1) / CLK_PERIOD_X10;
		return (c < 1) ? 1 : c;
	endfunction : asrwt_cyc

	function automatic int asrwt_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : asrwt_max

	// ------------------------------------------------------------------
	// states and register image
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_WR_LOW  = 3'b001,
		ST_WR_END  = 3'b010,
		ST_RD_WAIT = 3'b011,
		ST_TURN    = 3'b100
	} asrwt_state_type;

	typedef struct packed {
		asrwt_state_type   st;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        be_n;
		logic              cs_n;
		logic              oe_n;
		logic              we_n;
		logic              dq_oe;
		logic [DATA_W-1:0] rdata;
		logic              rsp_valid;
	} asrwt_regs_type;

	localparam asrwt_regs_type REGS_RESET = '{
		st:        ST_IDLE,
		addr:      20'h00000,
		wdata:     16'h0000,
		be_n:      2'h3,
		cs_n:      1'b1,
		oe_n:      1'b1,
		we_n:      1'b1,
		dq_oe:     1'b0,
		rdata:     16'h0000,
		rsp_valid: 1'b0
	};

endpackage : asrwt_pkg

// File: asrwt_sync2.sv
// Purpose: two-flop synchroniser for the data pins
// Assumes: read data is stable for the whole capture window
// Notes:   the first stage feeds only the second
module asrwt_sync2 #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  logic             clk_in,
	input  logic             rst_n_in,
	// data
	input  logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : asrwt_sync2

// File: asrwt_timer.sv
// Purpose: down counter that times each phase of a memory cycle
// Assumes: load value at least one
// Notes:   done is high when the count has run out
module asrwt_timer #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  logic             clk_in,
	input  logic             rst_n_in,
	// control
	input  logic             load_in,
	input  logic [WIDTH-1:0] value_in,
	output logic             done_out
);
	logic [WIDTH-1:0] cnt_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= '0;
		end else if (load_in) begin
			cnt_q <= value_in;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done_out = (cnt_q == '0);

endmodule : asrwt_timer

// File: asrwt_sram_model.sv
// Purpose: behavioural async 1M x 16 SRAM facing the host controller
// Assumes: array starts at zero; bench picks acc_ns, 10 prompt, 20 slow
// Notes:   between valid windows the outputs carry inverted noise
module asrwt_sram_model (
	// memory pins
	input  wire logic [19:0] addr_in,
	input  wire logic        cs_n_in,
	input  wire logic        cs2_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic        ub_n_in,
	input  wire logic        lb_n_in,
	input  wire logic [15:0] dq_in,
	// data drive
	output logic      [15:0] dq_out,
	output logic             dq_en_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------------
	// array and decode
	// ------------------------------------------------------------------
	bit   [15:0] mem [0:1048575];
	real         acc_ns = 10.0;
	int          gen = 0;
	logic        sel;
	logic        wr;
	logic        rd;
	initial dq_out = 16'h5A5A;
	assign sel = !cs_n_in && cs2_in;
	assign wr  = sel && !we_n_in && !(ub_n_in && lb_n_in);
	assign rd  = sel && !oe_n_in && we_n_in;
	// latched as the overlap ends: zero-delay pin skew at its start
	// cannot land a word at a stale address, and 0 ns hold is enough;
	// limitation: a write ended by a byte enable alone is not stored
	always @(negedge wr) begin
		if (!lb_n_in) mem[addr_in][7:0] = dq_in[7:0];
		if (!ub_n_in) mem[addr_in][15:8] = dq_in[15:8];
	end
	// ------------------------------------------------------------------
	// read path: old data 2.5 ns, noise, then the word
	// ------------------------------------------------------------------
	always @(addr_in, rd, ub_n_in, lb_n_in) begin
		gen = gen + 1;
		fork
			begin : access
				automatic int g = gen;
				#2.5 if (g == gen) dq_out = ~dq_out;
				#(acc_ns - 2.5) if (g == gen) dq_out = mem[addr_in];
			end
		join_none
	end
	// low-z 3 ns late, high-z within 4 ns
	assign #(3, 4) dq_en_out = rd && !(ub_n_in && lb_n_in);
endmodule : asrwt_sram_model

// File: asrwt_ctrl_test.sv
// Purpose: self-checking bench for the async SRAM host controller
// Assumes: GRADE 2 timing throughout
// Notes:   a released bus shows a toggling pattern, never a held value
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
	error_cnt++; $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module asrwt_ctrl_test;
	import asrwt_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in;
	logic        rst_n_in;
	logic        req_valid_in;
	logic        req_ready_out;
	logic        req_write_in;
	logic [19:0] req_addr_in;
	logic [15:0] req_wdata_in;
	logic [1:0]  req_byte_en_in;
	logic        rsp_valid_out;
	logic [15:0] rsp_rdata_out;
	logic [19:0] mem_addr_out;
	logic        cs_n;
	logic        cs2;
	logic        oe_n;
	logic        we_n;
	logic        ub_n;
	logic        lb_n;
	logic [15:0] bus;
	logic [15:0] mem_data_out;
	logic        mem_data_oe_out;
	logic [15:0] dq;
	logic        dq_en;
	logic [15:0] float_q = 16'hA5A5;
	logic [5:0]  pins;
	int          error_cnt = 0;
	int          tests_run = 0;
	assign pins = {cs_n, we_n, oe_n, ub_n, lb_n, mem_data_oe_out};
	// both drivers on: unknown, so a bus fight cannot pass unseen
	assign bus = (mem_data_oe_out && dq_en) ? 16'hXXXX : mem_data_oe_out ?
		mem_data_out : dq_en ? dq : float_q;
	asrwt_ctrl #(.GRADE(2)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
		.req_write_in(req_write_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_byte_en_in(req_byte_en_in),
		.rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
		.mem_addr_out(mem_addr_out), .first_chip_select_n_out(cs_n),
		.second_chip_select_high_out(cs2), .output_enable_n_out(oe_n),
		.write_enable_n_out(we_n), .upper_byte_n_out(ub_n),
		.lower_byte_n_out(lb_n), .mem_data_in(bus),
		.mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out));
	asrwt_sram_model MEM (.addr_in(mem_addr_out), .cs_n_in(cs_n),
		.cs2_in(cs2), .oe_n_in(oe_n), .we_n_in(we_n), .ub_n_in(ub_n),
		.lb_n_in(lb_n), .dq_in(bus), .dq_out(dq), .dq_en_out(dq_en));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) float_q <= ~float_q;
	// ------------------------------------------------------------------
	// pin watch
	// ------------------------------------------------------------------
	always @(negedge clk_in) begin
		if (rst_n_in) begin
			`CHK("cs2", ~cs_n, cs2)
			if (dq_en === 1'b1) `CHK("fight", 1'b0, mem_data_oe_out)
			if (we_n === 1'b0) `CHK("oe in wr", 1'b1, oe_n)
		end
	end
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task automatic give_up;
		error_cnt++;
		$display("mismatch wait exp done got timeout");
		close_out;
	endtask : give_up
	task automatic send(input logic w, input logic [19:0] a,
		input logic [15:0] d, input logic [1:0] be);
		int n;
		@(posedge clk_in);
		req_valid_in   <= 1'b1;
		req_write_in   <= w;
		req_addr_in    <= a;
		req_wdata_in   <= d;
		req_byte_en_in <= be;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (req_ready_out !== 1'b1 && n < 50);
		if (n >= 50) give_up;
		@(posedge clk_in);
		req_valid_in <= 1'b0;
	endtask : send
	task automatic wr(input logic [19:0] a, input logic [15:0] d,
		input logic [1:0] be);
		send(1'b1, a, d, be);
		@(negedge clk_in);
		`CHK("wr c1", {3'b001, ~be, 1'b1}, pins)
		`CHK("wr addr", a, mem_addr_out)
		`CHK("wr data", d, mem_data_out)
		@(negedge clk_in);
		`CHK("wr c2", {3'b001, ~be, 1'b1}, pins)
		@(negedge clk_in);
		`CHK("wr c3", {3'b011, ~be, 1'b1}, pins)
		`CHK("wr hold", d, mem_data_out)
		`CHK("wr addr2", a, mem_addr_out)
		@(negedge clk_in);
		`CHK("wr c4", {3'b011, ~be, 1'b1}, pins)
		`CHK("wr busy", 1'b0, req_ready_out)
		@(negedge clk_in);
		`CHK("wr c5", 6'b111110, pins)
		`CHK("wr rdy", 1'b1, req_ready_out)
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [1:0] be,
		input logic [15:0] exp);
		int n;
		send(1'b0, a, 16'h0000, be);
		@(negedge clk_in);
		`CHK("rd c1", {3'b010, ~be, 1'b0}, pins)
		`CHK("rd addr", a, mem_addr_out)
		n = 0;
		while (rsp_valid_out !== 1'b1 && n < 10) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 10) give_up;
		`CHK("rd data", exp, rsp_rdata_out)
		`CHK("rd lat", 4, n)
	endtask : rd
	// boundary addresses, write straight into read
	task automatic t_words;
		wr(20'h00000, 16'h1234, 2'b11);
		wr(20'hFFFFF, 16'hBEEF, 2'b11);
		rd(20'h00000, 2'b11, 16'h1234);
		rd(20'hFFFFF, 2'b11, 16'hBEEF);
	endtask : t_words
	// single-lane writes leave the other lane, disabled lanes read 0
	task automatic t_lanes;
		wr(20'h00010, 16'hAAAA, 2'b11);
		wr(20'h00010, 16'h5511, 2'b01);
		wr(20'h00010, 16'h77FF, 2'b10);
		rd(20'h00010, 2'b11, 16'h7711);
		rd(20'h00010, 2'b01, 16'h0011);
		rd(20'h00010, 2'b10, 16'h7700);
	endtask : t_lanes
	// slowest legal access, back-to-back reads of different words
	task automatic t_slow;
		MEM.acc_ns = 20.0;
		rd(20'hFFFFF, 2'b11, 16'hBEEF);
		rd(20'h00000, 2'b11, 16'h1234);
		MEM.acc_ns = 10.0;
	endtask : t_slow
	// reset in mid-write: pins idle at once, then a clean read
	task automatic t_reset;
		send(1'b1, 20'h00020, 16'hC0DE, 2'b11);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		@(negedge clk_in);
		`CHK("mid rst pins", 6'b111110, pins)
		`CHK("mid rst rdy", 1'b1, req_ready_out)
		`CHK("mid rst rsp", 1'b0, rsp_valid_out)
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(20'h00010, 2'b11, 16'h7711);
	endtask : t_reset
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_n_in       = 1'b0;
		req_valid_in   = 1'b0;
		req_write_in   = 1'b0;
		req_addr_in    = 20'h00000;
		req_wdata_in   = 16'h0000;
		req_byte_en_in = 2'h0;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		`CHK("rst pins", 6'b111110, pins)
		`CHK("rst rdy", 1'b1, req_ready_out)
		`CHK("rst rsp", 1'b0, rsp_valid_out)
		@(posedge clk_in);
		rst_n_in <= 1'b1;
		t_words;
		t_lanes;
		t_slow;
		t_reset;
		close_out;
	end
endmodule : asrwt_ctrl_test
